// ===== acc_mem.sv
// Per-channel accumulator store for the averaging sequencer.
// Assumes one write and one read port on the same clock; read data are registered.
`timescale 1ns/10ps
module acc_mem (
    input  wire logic                                clk_sys_i,
    input  wire logic                                wr_en_i,
    input  wire logic [avg_cfg_pkg::CHAN_W-1:0]      wr_addr_i,
    input  wire logic [avg_cfg_pkg::ACC_W-1:0]       wr_data_i,
    input  wire logic [avg_cfg_pkg::CHAN_W-1:0]      rd_addr_i,
    output logic      [avg_cfg_pkg::ACC_W-1:0]       rd_data_o
);
    logic [avg_cfg_pkg::ACC_W-1:0] mem_q [0:(1<<avg_cfg_pkg::CHAN_W)-1];

    // No reset: a channel's first sample never reads its old content
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule

// ===== adc_averaging_and_address_config.sv
// Averaging configuration, conversion sequencer and node address register.
// Assumes the serial engine, converter front end and control register share clk_sys_i;
// only the address strap pins arrive from outside and are synchronised here.
// Summary of operation
// - Order bit 0: all samples per channel first
// - Order bit 1: sweep cells, then aux; others take all samples per channel first
// - Cycling mode uses cell and aux settle periods
// - Analog field times analog-die group measurements
// - Order bit 0: analog field times cell averaging
// - Digital field times die temp and 1v8
// - Order bit 0: digital field times aux
// - Average samples, convergent round to 16 bits
// - Count codes 1..32 samples; 6-7 reserved
// - Respond only to frames with own node_id
// - Node address host-writable only during auto-addressing; strap load at any time
// - Auto-address bit set, cleared after next frame
`timescale 1ns/10ps
module adc_averaging_and_address_config (
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   reset_i,
    // Host register access from the serial command decoder
    input  wire logic                                   reg_wr_i,
    input  wire logic                                   reg_rd_i,
    input  wire logic [7:0]                             reg_addr_i,
    input  wire logic [7:0]                             reg_wdata_i,
    output logic      [7:0]                             reg_rdata_o,
    // Frame addressing and auto-address control
    input  wire logic                                   frame_done_i,
    input  wire logic [avg_cfg_pkg::NODE_ID_W-1:0]      frame_addr_i,
    output logic                                        addr_match_o,
    input  wire logic                                   addr_sel_i,
    input  wire logic                                   auto_addr_wr_i,
    input  wire logic [avg_cfg_pkg::NODE_ID_W-1:0]      gpio_addr_i,
    output logic                                        auto_address_o,
    // Sequencer start and channel selection
    input  wire logic                                   start_i,
    input  wire logic [avg_cfg_pkg::NUM_CHAN-1:0]       chan_mask_i,
    output logic                                        busy_o,
    // Converter front end
    output logic                                        convert_req_o,
    output logic      [avg_cfg_pkg::CHAN_W-1:0]         convert_chan_o,
    output logic      [1:0]                             period_kind_o,
    output logic      [avg_cfg_pkg::CYC_W-1:0]          avg_period_cycles_o,
    input  wire logic                                   sample_valid_i,
    input  wire logic [avg_cfg_pkg::SAMPLE_W-1:0]       sample_i,
    // Averaged result
    output logic                                        result_valid_o,
    output logic      [avg_cfg_pkg::CHAN_W-1:0]         result_chan_o,
    output logic      [avg_cfg_pkg::SAMPLE_W-1:0]       result_o
);
    localparam int CW = avg_cfg_pkg::CHAN_W;
    localparam int AW = avg_cfg_pkg::ACC_W;

    // Registers and sequencer state
    logic [7:0]                  cfg_q;
    logic [4:0]                  node_id_q;
    logic                        auto_q;
    logic [4:0]                  gpio_s1_q, gpio_s2_q;
    logic [26:0]                 mask_q;
    logic [CW-1:0]               chan_q;
    logic [5:0]                  pass_q;
    logic [1:0]                  kind_q;
    logic [9:0]                  cyc_q;
    logic [15:0]                 res_q;
    logic [CW-1:0]               res_chan_q;
    logic                        res_valid_q;
    logic [AW-1:0]               rd_data;
    avg_cfg_pkg::seq_state_t     state_q;

    // Lowest selected channel in [lo, hi]; bit 5 flags a hit
    function automatic logic [5:0] first_sel(input logic [26:0] m, input int lo, input int hi);
        logic [5:0] r;
        r = 6'h00;
        for (int i = avg_cfg_pkg::LAST_CHAN; i >= 0; i--) begin
            if (m[i] && i >= lo && i <= hi) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    // Cycle count of an averaging period code
    function automatic logic [9:0] period_cyc(input logic [1:0] code);
        logic [9:0] c;
        c = avg_cfg_pkg::AVG_P3_CYC;
        if (code == 2'h0) c = avg_cfg_pkg::AVG_P0_CYC;
        else if (code == 2'h1) c = avg_cfg_pkg::AVG_P1_CYC;
        else if (code == 2'h2) c = avg_cfg_pkg::AVG_P2_CYC;
        return c;
    endfunction

    // Field decode and per-channel group
    wire       order_cyc  = cfg_q[avg_cfg_pkg::ORDER_BIT];
    wire [1:0] analog_cd  = cfg_q[avg_cfg_pkg::ANALOG_LSB +: 2];
    wire [1:0] digital_cd = cfg_q[avg_cfg_pkg::DIGITAL_LSB +: 2];
    wire [2:0] count_cd   = cfg_q[avg_cfg_pkg::COUNT_LSB +: 3];
    wire       is_cell    = chan_q <= 5'(avg_cfg_pkg::CELL_LAST);
    wire       is_aux     = !is_cell && chan_q <= 5'(avg_cfg_pkg::AUX_LAST);
    wire       is_dtemp   = chan_q == 5'(avg_cfg_pkg::DIE_TEMP);
    wire       cyc_grp    = order_cyc && (is_cell || is_aux);
    // Reserved count codes fall back to the largest count
    wire [2:0] exp_cfg    = (count_cd > avg_cfg_pkg::COUNT_CODE_MAX) ?
                            avg_cfg_pkg::COUNT_CODE_MAX : count_cd;
    wire [2:0] exp_eff    = is_dtemp ? 3'h0 : exp_cfg;
    wire [5:0] n_last     = 6'((7'h01 << exp_eff) - 7'h01);
    wire       last_pass  = pass_q == n_last;
    wire [4:0] grp_hi     = is_cell ? 5'(avg_cfg_pkg::CELL_LAST) : 5'(avg_cfg_pkg::AUX_LAST);
    wire [4:0] grp_lo     = is_cell ? 5'(avg_cfg_pkg::CELL_FIRST) : 5'(avg_cfg_pkg::AUX_FIRST);

    // Period kind for the current request
    logic [1:0] kind_d;
    always_comb begin
        if (is_cell) begin
            kind_d = (cyc_grp || pass_q == 6'h00) ? avg_cfg_pkg::PERIOD_CELL_SETTLE
                                                  : avg_cfg_pkg::PERIOD_ANALOG_AVG;
        end else if (is_aux) begin
            kind_d = (cyc_grp || pass_q == 6'h00) ? avg_cfg_pkg::PERIOD_AUX_SETTLE
                                                  : avg_cfg_pkg::PERIOD_DIGITAL_AVG;
        end else if (chan_q == 5'(avg_cfg_pkg::ANALOG_GRP)) begin
            kind_d = avg_cfg_pkg::PERIOD_ANALOG_AVG;
        end else begin
            kind_d = avg_cfg_pkg::PERIOD_DIGITAL_AVG;
        end
    end
    wire [9:0] cyc_d = (kind_d == avg_cfg_pkg::PERIOD_ANALOG_AVG) ? period_cyc(analog_cd)
                                                                   : period_cyc(digital_cd);

    // Next channel candidates
    wire [5:0] nxt_any = first_sel(mask_q, int'(chan_q) + 1, avg_cfg_pkg::LAST_CHAN);
    wire [5:0] nxt_grp = first_sel(mask_q, int'(chan_q) + 1, int'(grp_hi));
    wire [5:0] grp_1st = first_sel(mask_q, int'(grp_lo), int'(grp_hi));
    wire [5:0] aft_grp = first_sel(mask_q, int'(grp_hi) + 1, avg_cfg_pkg::LAST_CHAN);
    wire [5:0] run_1st = first_sel(chan_mask_i, 0, avg_cfg_pkg::LAST_CHAN);

    // Accumulate, then shift with round-half-to-even
    wire [AW-1:0] acc_sum  = (pass_q == 6'h00 ? '0 : rd_data) + AW'(sample_i);
    wire [AW-1:0] quo      = acc_sum >> exp_eff;
    wire [AW-1:0] rem      = acc_sum & ((AW'(1) << exp_eff) - AW'(1));
    wire [AW-1:0] half     = (AW'(1) << exp_eff) >> 1;
    wire          round_up = (exp_eff != 3'h0) && (rem > half || (rem == half && quo[0]));
    wire [AW-1:0] rounded  = quo + AW'(round_up);
    wire          acc_we   = state_q == avg_cfg_pkg::SEQ_WAIT && sample_valid_i;

    acc_mem u_acc_mem (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (acc_we),
        .wr_addr_i (chan_q),
        .wr_data_i (acc_sum),
        .rd_addr_i (chan_q),
        .rd_data_o (rd_data)
    );

    // Sequencer: load timing, request, wait for sample, step to next
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= avg_cfg_pkg::SEQ_IDLE;
            mask_q  <= '0;
            chan_q  <= '0;
            pass_q  <= '0;
            kind_q  <= '0;
            cyc_q   <= '0;
        end else begin
            case (state_q)
                avg_cfg_pkg::SEQ_IDLE: begin
                    if (start_i && run_1st[5]) begin
                        mask_q  <= chan_mask_i;
                        chan_q  <= run_1st[4:0];
                        pass_q  <= '0;
                        state_q <= avg_cfg_pkg::SEQ_LOAD;
                    end
                end
                avg_cfg_pkg::SEQ_LOAD: begin
                    kind_q  <= kind_d;
                    cyc_q   <= cyc_d;
                    state_q <= avg_cfg_pkg::SEQ_REQ;
                end
                avg_cfg_pkg::SEQ_REQ: begin
                    state_q <= avg_cfg_pkg::SEQ_WAIT;
                end
                avg_cfg_pkg::SEQ_WAIT: begin
                    if (sample_valid_i) begin
                        state_q <= avg_cfg_pkg::SEQ_STEP;
                    end
                end
                avg_cfg_pkg::SEQ_STEP: begin
                    state_q <= avg_cfg_pkg::SEQ_LOAD;
                    if (!cyc_grp) begin
                        if (!last_pass) begin
                            pass_q <= pass_q + 6'h01;
                        end else if (nxt_any[5]) begin
                            pass_q <= '0;
                            chan_q <= nxt_any[4:0];
                        end else begin
                            state_q <= avg_cfg_pkg::SEQ_IDLE;
                        end
                    end else if (nxt_grp[5]) begin
                        chan_q <= nxt_grp[4:0];
                    end else if (!last_pass) begin
                        pass_q <= pass_q + 6'h01;
                        chan_q <= grp_1st[4:0];
                    end else if (aft_grp[5]) begin
                        pass_q <= '0;
                        chan_q <= aft_grp[4:0];
                    end else begin
                        state_q <= avg_cfg_pkg::SEQ_IDLE;
                    end
                end
                default: state_q <= avg_cfg_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Result register, one pulse per finished average
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            res_valid_q <= 1'b0;
            res_q       <= '0;
            res_chan_q  <= '0;
        end else begin
            res_valid_q <= acc_we && last_pass;
            if (acc_we && last_pass) begin
                res_q      <= rounded[15:0];
                res_chan_q <= chan_q;
            end
        end
    end

    // Host register writes; the strap pins are synchronised first
    wire cfg_wr  = reg_wr_i && reg_addr_i == avg_cfg_pkg::CONV_AVG_CFG_OFS;
    wire node_wr = reg_wr_i && reg_addr_i == avg_cfg_pkg::NODE_ADDR_OFS;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q     <= avg_cfg_pkg::CONV_AVG_CFG_RST;
            node_id_q <= avg_cfg_pkg::NODE_ID_RST;
            auto_q    <= 1'b0;
            gpio_s1_q <= '0;
            gpio_s2_q <= '0;
        end else begin
            gpio_s1_q <= gpio_addr_i;
            gpio_s2_q <= gpio_s1_q;
            if (cfg_wr) begin
                cfg_q <= reg_wdata_i;
            end
            if (auto_addr_wr_i && !addr_sel_i) begin
                node_id_q <= gpio_s2_q;
            end else if (node_wr && auto_q) begin
                node_id_q <= reg_wdata_i[4:0];
            end
            // Arming wins over a frame ending in the same cycle
            if (auto_addr_wr_i && addr_sel_i) begin
                auto_q <= 1'b1;
            end else if (frame_done_i) begin
                auto_q <= 1'b0;
            end
        end
    end

    // Read data registered; reserved address bits read as zero
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            if (reg_addr_i == avg_cfg_pkg::CONV_AVG_CFG_OFS) reg_rdata_o <= cfg_q;
            else if (reg_addr_i == avg_cfg_pkg::NODE_ADDR_OFS) reg_rdata_o <= {3'h0, node_id_q};
            else reg_rdata_o <= '0;
        end
    end

    // Outputs
    assign addr_match_o        = frame_addr_i == node_id_q;
    assign auto_address_o      = auto_q;
    assign busy_o              = state_q != avg_cfg_pkg::SEQ_IDLE;
    assign convert_req_o       = state_q == avg_cfg_pkg::SEQ_REQ;
    assign convert_chan_o      = chan_q;
    assign period_kind_o       = kind_q;
    assign avg_period_cycles_o = cyc_q;
    assign result_valid_o      = res_valid_q;
    assign result_chan_o       = res_chan_q;
    assign result_o            = res_q;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic aux_seen_q;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) aux_seen_q <= 1'b0;
        else if (start_i && !busy_o) aux_seen_q <= 1'b0;
        else if (convert_req_o && is_aux) aux_seen_q <= 1'b1;
    end
    sequence req_later_s; convert_req_o && !order_cyc && pass_q != 6'h00; endsequence
    node_lock_a: assert property (node_wr && !auto_q && !auto_addr_wr_i |=> $stable(node_id_q))
        else $error("node address changed while not armed");
    node_take_a: assert property (node_wr && auto_q && !auto_addr_wr_i
                                  |=> node_id_q == $past(reg_wdata_i[4:0]))
        else $error("armed node address write lost");
    // Match must follow a freshly written address, not just mirror the compare
    addr_match_a: assert property (node_wr && auto_q && !auto_addr_wr_i
                                   |=> addr_match_o == (frame_addr_i == $past(reg_wdata_i[4:0])))
        else $error("frame address match wrong");
    auto_clear_a: assert property (frame_done_i && !auto_addr_wr_i |=> !auto_q)
        else $error("auto address bit not cleared by frame");
    auto_arm_a: assert property (auto_addr_wr_i && addr_sel_i |=> auto_q)
        else $error("auto address not armed");
    same_chan_a: assert property (req_later_s |-> chan_q == $past(chan_q, 4))
        else $error("channel changed before its samples finished");
    cell_avg_a: assert property ((req_later_s and is_cell)
                  |-> kind_q == avg_cfg_pkg::PERIOD_ANALOG_AVG && cyc_q == period_cyc(analog_cd))
        else $error("cell averaging period wrong");
    aux_avg_a: assert property ((req_later_s and is_aux)
                  |-> kind_q == avg_cfg_pkg::PERIOD_DIGITAL_AVG && cyc_q == period_cyc(digital_cd))
        else $error("aux averaging period wrong");
    cycle_settle_a: assert property (convert_req_o && order_cyc && is_cell
                  |-> kind_q == avg_cfg_pkg::PERIOD_CELL_SETTLE)
        else $error("cycling cell sample without settle period");
    group_order_a: assert property (convert_req_o && aux_seen_q |-> !is_cell)
        else $error("cell sampled after aux started");
    single_avg_a: assert property (acc_we && exp_eff == 3'h0 |=> result_valid_o
                                   && result_o == $past(sample_i))
        else $error("single sample result differs");
endmodule

// ===== adc_averaging_and_address_config_tb_top.sv
// Self-checking bench for the averaging configuration and node address block.
// Assumes the bench alone drives every port and answers each conversion request.
`timescale 1ns/10ps
module adc_averaging_and_address_config_tb_top;
    logic        clk_sys_i      = 1'b0;
    logic        reset_i        = 1'b1;
    logic        reg_wr_i       = 1'b0;
    logic        reg_rd_i       = 1'b0;
    logic [7:0]  reg_addr_i     = 8'h00;
    logic [7:0]  reg_wdata_i    = 8'h00;
    logic [7:0]  reg_rdata_o;
    logic        frame_done_i   = 1'b0;
    logic [4:0]  frame_addr_i   = 5'h00;
    logic        addr_match_o;
    logic        addr_sel_i     = 1'b0;
    logic        auto_addr_wr_i = 1'b0;
    logic [4:0]  gpio_addr_i    = 5'h0b;
    logic        auto_address_o;
    logic        start_i        = 1'b0;
    logic [26:0] chan_mask_i    = 27'h0;
    logic        busy_o;
    logic        convert_req_o;
    logic [4:0]  convert_chan_o;
    logic [1:0]  period_kind_o;
    logic [9:0]  avg_period_cycles_o;
    logic        sample_valid_i = 1'b0;
    logic [15:0] sample_i       = 16'h0000;
    logic        result_valid_o;
    logic [4:0]  result_chan_o;
    logic [15:0] result_o;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          nsmp = 1;
    int          kexp = 0;
    logic [31:0] seed = 32'hdbe7bcf8;
    logic [7:0]  rd_q[$];
    logic [16:0] req_q[$];
    logic [20:0] res_q[$];
    logic [20:0] acc[32] = '{default: 21'h0};
    int          cnt[32] = '{default: 0};
    logic [9:0]  per_tbl[4] = '{10'h0cf, 10'h12a, 10'h191, 10'h276};

    adc_averaging_and_address_config dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_done_i(frame_done_i),
        .frame_addr_i(frame_addr_i), .addr_match_o(addr_match_o), .addr_sel_i(addr_sel_i),
        .auto_addr_wr_i(auto_addr_wr_i), .gpio_addr_i(gpio_addr_i),
        .auto_address_o(auto_address_o), .start_i(start_i), .chan_mask_i(chan_mask_i),
        .busy_o(busy_o), .convert_req_o(convert_req_o), .convert_chan_o(convert_chan_o),
        .period_kind_o(period_kind_o), .avg_period_cycles_o(avg_period_cycles_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i),
        .result_valid_o(result_valid_o), .result_chan_o(result_chan_o), .result_o(result_o));

    // 50 MHz system clock
    always #10 clk_sys_i = ~clk_sys_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Shift with ties to even; k of zero passes the sum through
    function automatic logic [15:0] rnd(input logic [20:0] s, input int k);
        logic [20:0] q;
        logic [20:0] r;
        q = s >> k;
        r = s - (q << k);
        if (k > 0 && (r > (21'h1 << (k-1)) || (r == (21'h1 << (k-1)) && q[0])))
            q = q + 21'h1;
        return q[15:0];
    endfunction

    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Leading edge wait keeps a strobe from being lowered and raised in one time step
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        if (w) reg_wr_i <= 1'b1;
        else begin
            reg_rd_i <= 1'b1;
            rd_q.push_back(d);
        end
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask

    task automatic exp_req(input logic [4:0] ch, input logic [1:0] k, input logic [9:0] c, int n);
        repeat (n) req_q.push_back({ch, k, c});
    endtask

    // One conversion run; expected requests are queued by the caller
    task automatic run(input logic [7:0] cfg, input logic [26:0] mask);
        int i;
        bus(1'b1, 8'h07, cfg);
        kexp = int'(cfg[2:0]);
        nsmp = 1 << kexp;
        @(posedge clk_sys_i);
        start_i     <= 1'b1;
        chan_mask_i <= mask;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        for (i = 0; i < 3000 && (busy_o !== 1'b0 || i < 2); i++) @(posedge clk_sys_i);
        check(21'(busy_o), 21'h0);
        check(21'(req_q.size()), 21'h0);
        check(21'(res_q.size()), 21'h0);
    endtask

    // Converter stand-in: answers each request one cycle later with a random sample
    always @(posedge clk_sys_i) begin
        sample_valid_i <= (convert_req_o === 1'b1);
        if (convert_req_o === 1'b1) begin
            check({convert_chan_o, period_kind_o, period_kind_o[1] ? avg_period_cycles_o : 10'h0},
                  req_q.pop_front());
            seed = xs(seed);
            sample_i <= seed[15:0];
            acc[convert_chan_o] = acc[convert_chan_o] + 21'(seed[15:0]);
            cnt[convert_chan_o]++;
            // Die temperature is never averaged, whatever the count code
            if (cnt[convert_chan_o] == (convert_chan_o == 5'h19 ? 1 : nsmp)) begin
                res_q.push_back({convert_chan_o,
                                 rnd(acc[convert_chan_o], convert_chan_o == 5'h19 ? 0 : kexp)});
                acc[convert_chan_o] = 21'h0;
                cnt[convert_chan_o] = 0;
            end
        end
    end

    // Output watchers take the oldest note off each queue
    always @(posedge clk_sys_i) begin
        if (result_valid_o === 1'b1) check({result_chan_o, result_o}, res_q.pop_front());
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    always @(posedge clk_sys_i) begin
        if (reg_rd_i === 1'b1) begin
            #1 check(21'(reg_rdata_o), 21'(rd_q.pop_front()));
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        bus(1'b0, 8'h07, 8'h78);
        bus(1'b0, 8'h08, 8'h00);
        // Address write while not armed must be dropped
        bus(1'b1, 8'h0a, 8'h13);
        bus(1'b0, 8'h0a, 8'h00);
        @(posedge clk_sys_i);
        addr_sel_i     <= 1'b1;
        auto_addr_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        auto_addr_wr_i <= 1'b0;
        #1 check(21'(auto_address_o), 21'h1);
        bus(1'b1, 8'h0a, 8'h13);
        bus(1'b0, 8'h0a, 8'h13);
        @(posedge clk_sys_i);
        frame_addr_i <= 5'h13;
        #1 check(21'(addr_match_o), 21'h1);
        @(posedge clk_sys_i);
        frame_addr_i <= 5'h12;
        frame_done_i <= 1'b1;
        @(posedge clk_sys_i);
        frame_done_i <= 1'b0;
        #1 check(21'(addr_match_o), 21'h0);
        check(21'(auto_address_o), 21'h0);
        bus(1'b1, 8'h0a, 8'h05);
        bus(1'b0, 8'h0a, 8'h13);
        // Strap load with the source select low leaves the bit clear
        @(posedge clk_sys_i);
        addr_sel_i     <= 1'b0;
        auto_addr_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        auto_addr_wr_i <= 1'b0;
        bus(1'b0, 8'h0a, 8'h0b);
        check(21'(auto_address_o), 21'h0);
        // Digital period codes on an aux channel, two samples each
        for (int d = 0; d < 4; d++) begin
            exp_req(5'd17, 2'h1, 10'h0, 1);
            exp_req(5'd17, 2'h3, per_tbl[d], 1);
            run(8'h61 | 8'(d << 3), 27'h1 << 17);
        end
        // Channel cycling: cells swept per pass before aux
        for (int p = 0; p < 2; p++) exp_req(5'd0, 2'h0, 10'h0, 1);
        for (int p = 0; p < 2; p++) exp_req(5'd1, 2'h0, 10'h0, 1);
        req_q = {req_q[0], req_q[2], req_q[1], req_q[3]};
        exp_req(5'd16, 2'h1, 10'h0, 2);
        run(8'hf9, 27'h0_01_0003);
        // Analog group, die temperature and core supply; die temperature takes one sample
        exp_req(5'h18, 2'h2, 10'h276, 2);
        exp_req(5'h19, 2'h3, per_tbl[2], 1);
        exp_req(5'h1a, 2'h3, per_tbl[2], 2);
        run(8'h71, 27'h7 << 24);
        // Every sample count on one cell
        for (int c = 0; c < 6; c++) begin
            exp_req(5'd5, 2'h0, 10'h0, 1);
            exp_req(5'd5, 2'h2, 10'h276, (1 << c) - 1);
            run(8'h78 | 8'(c), 27'h1 << 5);
        end
        bus(1'b0, 8'h07, 8'h7d);
        tally_and_finish();
    end
endmodule

// ===== avg_cfg_pkg.sv
// Constants, field layouts and types for the conversion averaging and node address block.
// Assumes a single 50 MHz system clock and byte-wide host register accesses.
package avg_cfg_pkg;

    // Register offsets
    localparam logic [7:0] CONV_AVG_CFG_OFS = 8'h07;
    localparam logic [7:0] NODE_ADDR_OFS    = 8'h0a;

    // Field positions of the averaging configuration register
    localparam int ORDER_BIT    = 7;
    localparam int ANALOG_LSB   = 5;
    localparam int DIGITAL_LSB  = 3;
    localparam int COUNT_LSB    = 0;
    localparam int NODE_ID_W    = 5;

    // Reset values
    localparam logic [7:0]           CONV_AVG_CFG_RST = 8'h78;
    localparam logic [NODE_ID_W-1:0] NODE_ID_RST      = 5'h00;

    // Largest count exponent (32 samples); codes above it are reserved
    localparam logic [2:0] COUNT_CODE_MAX = 3'h5;

    // Channel map of the sequencer
    localparam int NUM_CHAN   = 27;
    localparam int CELL_FIRST = 0;
    localparam int CELL_LAST  = 15;
    localparam int AUX_FIRST  = 16;
    localparam int AUX_LAST   = 23;
    localparam int ANALOG_GRP = 24;
    localparam int DIE_TEMP   = 25;
    localparam int CORE_1V8   = 26;
    localparam int LAST_CHAN  = 26;

    // Datapath widths
    localparam int SAMPLE_W = 16;
    localparam int ACC_W    = 21;
    localparam int CHAN_W   = 5;
    localparam int PASS_W   = 6;
    localparam int CYC_W    = 10;

    // Averaging periods in ns and their cycle counts at the system clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int AVG_P0_NS     = 4130;
    localparam int AVG_P1_NS     = 5960;
    localparam int AVG_P2_NS     = 8020;
    localparam int AVG_P3_NS     = 12600;
    localparam logic [CYC_W-1:0] AVG_P0_CYC = CYC_W'((AVG_P0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CYC_W-1:0] AVG_P1_CYC = CYC_W'((AVG_P1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CYC_W-1:0] AVG_P2_CYC = CYC_W'((AVG_P2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CYC_W-1:0] AVG_P3_CYC = CYC_W'((AVG_P3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Which timing governs a conversion request
    typedef enum logic [1:0] {
        PERIOD_CELL_SETTLE  = 2'h0,
        PERIOD_AUX_SETTLE   = 2'h1,
        PERIOD_ANALOG_AVG   = 2'h2,
        PERIOD_DIGITAL_AVG  = 2'h3
    } period_kind_t;

    // Sequencer states, Gray along idle-load-request-wait-step
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_LOAD = 3'h1,
        SEQ_REQ  = 3'h3,
        SEQ_WAIT = 3'h2,
        SEQ_STEP = 3'h6
    } seq_state_t;

endpackage
